// ### core/rtc_params.svh
// Register offsets, field positions, reset values and limits of the time and calendar counter
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Register offsets of the time block
`define RTC_OFS_SECONDS 4'h2
`define RTC_OFS_MINUTES 4'h3
`define RTC_OFS_HOURS 4'h4
`define RTC_OFS_DAY 4'h5
`define RTC_OFS_WEEKDAY 4'h6
`define RTC_OFS_CENTURY_MONTH 4'h7
`define RTC_OFS_YEAR 4'h8

// Field positions
`define RTC_FLAG_BIT 7
`define RTC_CENTURY_BIT 7
`define RTC_SEC_MSB 6
`define RTC_MIN_MSB 6
`define RTC_HOUR_MSB 5
`define RTC_DAY_MSB 5
`define RTC_WDAY_MSB 2
`define RTC_MONTH_MSB 4

// Reset values
`define RTC_RST_FLAG 1'b1
`define RTC_RST_SECONDS 7'h00
`define RTC_RST_MINUTES 7'h00
`define RTC_RST_HOURS 6'h00
`define RTC_RST_DAY 6'h01
`define RTC_RST_WEEKDAY 3'h0
`define RTC_RST_CENTURY 1'b0
`define RTC_RST_MONTH 5'h01
`define RTC_RST_YEAR 8'h00

// Counting limits in BCD
`define RTC_LAST_SECOND 8'h59
`define RTC_LAST_MINUTE 8'h59
`define RTC_LAST_HOUR 8'h23
`define RTC_LAST_WEEKDAY 8'h06
`define RTC_LAST_MONTH 8'h12
`define RTC_LAST_YEAR 8'h99
`define RTC_FIRST_ZERO 8'h00
`define RTC_FIRST_ONE 8'h01
`define RTC_MONTH_FEB 5'h02
`define RTC_MONTH_APR 5'h04
`define RTC_MONTH_JUN 5'h06
`define RTC_MONTH_SEP 5'h09
`define RTC_MONTH_NOV 5'h11
`define RTC_DAYS_LONG 8'h31
`define RTC_DAYS_SHORT 8'h30
`define RTC_DAYS_FEB 8'h28
`define RTC_DAYS_LEAP 8'h29

`endif

// ### core/rtc_pkg.sv
// Types shared by the time and calendar counter modules
package rtc_pkg;

   typedef enum logic [3:0] {
      REG_SECONDS = 4'b0010,
      REG_MINUTES = 4'b0011,
      REG_HOURS = 4'b0100,
      REG_DAY = 4'b0101,
      REG_WEEKDAY = 4'b0110,
      REG_CENTURY_MONTH = 4'b0111,
      REG_YEAR = 4'b1000
   } register_index_type;

   typedef struct packed {
      logic [6:0] seconds;
      logic integrity;
      logic [6:0] minutes;
      logic [5:0] hours;
      logic [5:0] day;
      logic [2:0] weekday;
      logic century;
      logic [4:0] month;
      logic [7:0] year;
      logic [3:0] pointer;
      logic pending;
      logic tick_seen;
      logic [7:0] read_data;
   } time_state_type;

   typedef struct packed {
      logic [2:0] stage1;
      logic [2:0] stage2;
      logic [2:0] stage3;
      logic [2:0] stable;
   } sync_state_type;

endpackage : rtc_pkg

// ### core/sync_if.sv
// Filtered pin levels passed from the synchroniser to the counter
interface sync_if;
   logic tick;
   logic supply_low;
   logic osc_stop;

   modport producer (output tick, output supply_low, output osc_stop);
   modport consumer (input tick, input supply_low, input osc_stop);
endinterface : sync_if

// ### core/pin_sync.sv
// Three-stage synchroniser and agreement filter for the pin inputs
module pin_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Raw pins
   input wire logic tick_raw_in,
   input wire logic supply_low_raw_in,
   input wire logic osc_stop_raw_in,
   // Filtered levels
   sync_if.producer sync
);

   rtc_pkg::sync_state_type state;
   rtc_pkg::sync_state_type next_state;

   always_comb begin
      next_state = state;
      if (ce_in) begin
         next_state.stage1 = {tick_raw_in, supply_low_raw_in, osc_stop_raw_in};
         next_state.stage2 = state.stage1;
         next_state.stage3 = state.stage2;
         // A change is believed only once two late stages agree
         for (int i = 0; i < 3; i++) begin
            if (state.stage2[i] == state.stage3[i]) begin
               next_state.stable[i] = state.stage3[i];
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync.tick = state.stable[2];
   assign sync.supply_low = state.stable[1];
   assign sync.osc_stop = state.stable[0];

endmodule : pin_sync

// ### core/bcd_time_calendar_counter.sv
// BCD time and calendar counter with access freeze and pending tick
`include "rtc_params.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Supply below threshold sets the clock-integrity flag.
// - Flag stays set until the serial host writes it clear.
// - A stopped oscillator also sets the clock-integrity flag.
// - Minutes: tens 0-5 in bits 6:4, units in 3:0, bit 7 unused.
// - Hours: tens 0-2 in bits 5:4, units in 3:0, bits 7:6 unused.
// - Day: tens 0-3 in bits 5:4, units in 3:0, top bits unused.
// - February has 29 days when year divides by four, year 00 included.
// - Weekday 0-6 in bits 2:0; 0 Sunday by default, software may remap.
// - Century bit 7 toggles when year rolls 99 to 00.
// - Month BCD: tens bit 4, units 3:0, January 00001, December 10010.
// - Year: two BCD digits, tens 7:4, units 3:0.
// - One-second tick advances seconds, carries ripple up to years.
// - Counting of registers 02h-08h freezes during a serial access.
// - After access ends, one held tick is applied; only one is held.
// - Flag in seconds bit 7, set at power-up; seconds BCD below it.
module bcd_time_calendar_counter (
   // Clock, reset and enable
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Pins from the oscillator and supply monitor
   input wire logic tick_1hz_in,
   input wire logic supply_low_in,
   input wire logic osc_stopped_in,
   // Byte port from the serial slave engine
   input wire logic access_active_in,
   input wire logic pointer_load_in,
   input wire logic write_en_in,
   input wire logic read_en_in,
   input wire logic [7:0] write_data_in,
   // Answers
   output logic [7:0] read_data_out,
   output logic integrity_flag_out,
   output logic tick_pending_out
);

   //////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [7:0] bcd_step(input logic [7:0] value, input logic [7:0] last,
                                           input logic [7:0] first);
      logic [7:0] result;
      result = value;
      // Out-of-range values written by software fall back to the first value
      if (value >= last) begin
         result = first;
      end else if (value[3:0] >= 4'h9) begin
         result = {4'(value[7:4] + 4'h1), 4'h0};
      end else begin
         result = {value[7:4], 4'(value[3:0] + 4'h1)};
      end
      return result;
   endfunction : bcd_step

   function automatic logic leap_year(input logic [7:0] year);
      logic result;
      result = 1'b0;
      // BCD divisibility by four: even tens need 0,4,8, odd tens need 2,6
      if (!year[4]) begin
         result = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) || (year[3:0] == 4'h8);
      end else begin
         result = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
      end
      return result;
   endfunction : leap_year

   function automatic logic [7:0] month_last_day(input logic [4:0] month, input logic [7:0] year);
      logic [7:0] result;
      result = `RTC_DAYS_LONG;
      if (month == `RTC_MONTH_FEB) begin
         result = leap_year(year) ? `RTC_DAYS_LEAP : `RTC_DAYS_FEB;
      end else if (month == `RTC_MONTH_APR || month == `RTC_MONTH_JUN ||
                   month == `RTC_MONTH_SEP || month == `RTC_MONTH_NOV) begin
         result = `RTC_DAYS_SHORT;
      end
      return result;
   endfunction : month_last_day

   function automatic logic [7:0] read_register(input rtc_pkg::time_state_type s);
      logic [7:0] result;
      result = 8'h00;
      case (rtc_pkg::register_index_type'(s.pointer))
         rtc_pkg::REG_SECONDS: result = {s.integrity, s.seconds};
         rtc_pkg::REG_MINUTES: result = {1'b0, s.minutes};
         rtc_pkg::REG_HOURS: result = {2'b00, s.hours};
         rtc_pkg::REG_DAY: result = {2'b00, s.day};
         rtc_pkg::REG_WEEKDAY: result = {5'h00, s.weekday};
         rtc_pkg::REG_CENTURY_MONTH: result = {s.century, 2'b00, s.month};
         rtc_pkg::REG_YEAR: result = s.year;
         default: result = 8'h00;
      endcase
      return result;
   endfunction : read_register

   //////////////////////////////////////////////////////////////////////////
   // Pin synchroniser

   sync_if sync ();

   pin_sync u_pin_sync (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .tick_raw_in(tick_1hz_in),
      .supply_low_raw_in(supply_low_in),
      .osc_stop_raw_in(osc_stopped_in),
      .sync(sync)
   );

   //////////////////////////////////////////////////////////////////////////
   // Counting and register access

   rtc_pkg::time_state_type state;
   rtc_pkg::time_state_type next_state;
   logic tick_edge;
   logic advance;
   logic flag_event;

   assign tick_edge = sync.tick && !state.tick_seen;
   assign flag_event = sync.supply_low || sync.osc_stop;
   // A held tick or a fresh one advances the time only outside an access
   assign advance = !access_active_in && (state.pending || tick_edge);

   always_comb begin
      logic [7:0] step;
      logic carry;
      step = 8'h00;
      carry = 1'b0;
      next_state = state;
      if (ce_in) begin
         next_state.tick_seen = sync.tick;
         if (access_active_in) begin
            // Only one tick is held; a second one in the same access is lost
            if (tick_edge) begin
               next_state.pending = 1'b1;
            end
         end else begin
            // Held tick serviced now; a fresh tick in the same cycle is held for the next
            next_state.pending = state.pending && tick_edge;
         end
         if (advance) begin
            step = bcd_step({1'b0, state.seconds}, `RTC_LAST_SECOND, `RTC_FIRST_ZERO);
            next_state.seconds = step[6:0];
            carry = ({1'b0, state.seconds} >= `RTC_LAST_SECOND);
            if (carry) begin
               step = bcd_step({1'b0, state.minutes}, `RTC_LAST_MINUTE, `RTC_FIRST_ZERO);
               next_state.minutes = step[6:0];
               carry = ({1'b0, state.minutes} >= `RTC_LAST_MINUTE);
            end
            if (carry) begin
               step = bcd_step({2'b00, state.hours}, `RTC_LAST_HOUR, `RTC_FIRST_ZERO);
               next_state.hours = step[5:0];
               carry = ({2'b00, state.hours} >= `RTC_LAST_HOUR);
            end
            if (carry) begin
               step = bcd_step({5'h00, state.weekday}, `RTC_LAST_WEEKDAY, `RTC_FIRST_ZERO);
               next_state.weekday = step[2:0];
               step = bcd_step({2'b00, state.day}, month_last_day(state.month, state.year),
                               `RTC_FIRST_ONE);
               next_state.day = step[5:0];
               carry = ({2'b00, state.day} >= month_last_day(state.month, state.year));
            end
            if (carry) begin
               step = bcd_step({3'b000, state.month}, `RTC_LAST_MONTH, `RTC_FIRST_ONE);
               next_state.month = step[4:0];
               carry = ({3'b000, state.month} >= `RTC_LAST_MONTH);
            end
            if (carry) begin
               next_state.year = bcd_step(state.year, `RTC_LAST_YEAR, `RTC_FIRST_ZERO);
               if (state.year >= `RTC_LAST_YEAR) begin
                  next_state.century = !state.century;
               end
            end
         end
         if (pointer_load_in) begin
            next_state.pointer = write_data_in[3:0];
         end else if (write_en_in) begin
            case (rtc_pkg::register_index_type'(state.pointer))
               rtc_pkg::REG_SECONDS: begin
                  next_state.seconds = write_data_in[`RTC_SEC_MSB:0];
                  next_state.integrity = write_data_in[`RTC_FLAG_BIT];
               end
               rtc_pkg::REG_MINUTES: next_state.minutes = write_data_in[`RTC_MIN_MSB:0];
               rtc_pkg::REG_HOURS: next_state.hours = write_data_in[`RTC_HOUR_MSB:0];
               rtc_pkg::REG_DAY: next_state.day = write_data_in[`RTC_DAY_MSB:0];
               rtc_pkg::REG_WEEKDAY: next_state.weekday = write_data_in[`RTC_WDAY_MSB:0];
               rtc_pkg::REG_CENTURY_MONTH: begin
                  next_state.century = write_data_in[`RTC_CENTURY_BIT];
                  next_state.month = write_data_in[`RTC_MONTH_MSB:0];
               end
               rtc_pkg::REG_YEAR: next_state.year = write_data_in;
               default: next_state.year = next_state.year;
            endcase
            next_state.pointer = 4'(state.pointer + 4'h1);
         end else if (read_en_in) begin
            next_state.read_data = read_register(state);
            next_state.pointer = 4'(state.pointer + 4'h1);
         end
         // A low-supply or stopped-oscillator event beats a clearing write
         if (flag_event) begin
            next_state.integrity = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state.seconds <= `RTC_RST_SECONDS;
         state.integrity <= `RTC_RST_FLAG;
         state.minutes <= `RTC_RST_MINUTES;
         state.hours <= `RTC_RST_HOURS;
         state.day <= `RTC_RST_DAY;
         state.weekday <= `RTC_RST_WEEKDAY;
         state.century <= `RTC_RST_CENTURY;
         state.month <= `RTC_RST_MONTH;
         state.year <= `RTC_RST_YEAR;
         state.pointer <= 4'h0;
         state.pending <= 1'b0;
         state.tick_seen <= 1'b0;
         state.read_data <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   assign read_data_out = state.read_data;
   assign integrity_flag_out = state.integrity;
   assign tick_pending_out = state.pending;

   //////////////////////////////////////////////////////////////////////////
   // Assertions

   logic seconds_write;
   assign seconds_write = write_en_in && !pointer_load_in && (state.pointer == `RTC_OFS_SECONDS);

   property p_low_sets_flag;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && sync.supply_low) |=> state.integrity;
   endproperty
   a_low_sets_flag: assert property (p_low_sets_flag) else $error("supply low did not set flag");

   property p_flag_sticky;
      @(posedge clk_in) disable iff (!resetn_in)
         (state.integrity && !(ce_in && seconds_write && !write_data_in[7])) |=> state.integrity;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without host write");

   property p_osc_sets_flag;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && sync.osc_stop) |=> state.integrity;
   endproperty
   a_osc_sets_flag: assert property (p_osc_sets_flag) else $error("oscillator stop did not set flag");

   property p_hours_unused_zero;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && read_en_in && !pointer_load_in && !write_en_in && state.pointer == `RTC_OFS_HOURS)
            |=> (read_data_out[7:6] == 2'b00) && (read_data_out[5:0] == $past(state.hours));
   endproperty
   a_hours_unused_zero: assert property (p_hours_unused_zero) else $error("hours read wrong");

   property p_freeze_in_access;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && access_active_in && !write_en_in) |=> $stable(state.seconds) && $stable(state.year);
   endproperty
   a_freeze_in_access: assert property (p_freeze_in_access) else $error("time moved during access");

   property p_pending_serviced;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && !access_active_in && state.pending && !tick_edge && !write_en_in
          && state.seconds != 7'h59) |=> !state.pending && (state.seconds != $past(state.seconds));
   endproperty
   a_pending_serviced: assert property (p_pending_serviced) else $error("held tick not applied");

   property p_seconds_roll;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && advance && state.seconds == 7'h59 && !write_en_in)
            |=> (state.seconds == 7'h00) && (state.minutes != $past(state.minutes));
   endproperty
   a_seconds_roll: assert property (p_seconds_roll) else $error("seconds rollover wrong");

   property p_century_toggle;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && advance && !write_en_in && state.seconds == 7'h59 && state.minutes == 7'h59
          && state.hours == 6'h23 && state.day == 6'h31 && state.month == 5'h12 && state.year == 8'h99)
            |=> (state.year == 8'h00) && (state.century != $past(state.century)) && (state.month == 5'h01);
   endproperty
   a_century_toggle: assert property (p_century_toggle) else $error("century did not toggle");

   property p_leap_feb;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && advance && !write_en_in && state.seconds == 7'h59 && state.minutes == 7'h59
          && state.hours == 6'h23 && state.day == 6'h28 && state.month == 5'h02 && state.year == 8'h00)
            |=> (state.day == 6'h29);
   endproperty
   a_leap_feb: assert property (p_leap_feb) else $error("leap day skipped");

   property p_pointer_step;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && !pointer_load_in && (write_en_in || read_en_in))
            |=> state.pointer == 4'($past(state.pointer) + 4'h1);
   endproperty
   a_pointer_step: assert property (p_pointer_step) else $error("pointer did not step");

   property p_set_beats_clear;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && flag_event && seconds_write) |=> state.integrity;
   endproperty
   a_set_beats_clear: assert property (p_set_beats_clear) else $error("clearing write beat flag set");

   property p_pending_held;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && access_active_in && (state.pending || tick_edge)) |=> state.pending;
   endproperty
   a_pending_held: assert property (p_pending_held) else $error("tick lost during access");

   property p_seconds_read;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && read_en_in && !pointer_load_in && !write_en_in && state.pointer == `RTC_OFS_SECONDS)
            |=> read_data_out == {$past(state.integrity), $past(state.seconds)};
   endproperty
   a_seconds_read: assert property (p_seconds_read) else $error("seconds read wrong");

   property p_minutes_read;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && read_en_in && !pointer_load_in && !write_en_in && state.pointer == `RTC_OFS_MINUTES)
            |=> read_data_out == {1'b0, $past(state.minutes)};
   endproperty
   a_minutes_read: assert property (p_minutes_read) else $error("minutes read wrong");

   property p_month_read;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && read_en_in && !pointer_load_in && !write_en_in && state.pointer == `RTC_OFS_CENTURY_MONTH)
            |=> read_data_out == {$past(state.century), 2'b00, $past(state.month)};
   endproperty
   a_month_read: assert property (p_month_read) else $error("century and month read wrong");

   property p_tick_counts;
      @(posedge clk_in) disable iff (!resetn_in)
         (ce_in && !access_active_in && tick_edge && !state.pending && !write_en_in
          && state.seconds[3:0] < 4'h9 && state.seconds < 7'h59)
            |=> state.seconds == 7'($past(state.seconds) + 7'h01);
   endproperty
   a_tick_counts: assert property (p_tick_counts) else $error("tick did not add one second");

endmodule : bcd_time_calendar_counter

// ### testbench/host_model.sv
// Host-side model driving the byte port as the serial slave engine would
module host_model (
   // Clock
   input wire logic clk_in,
   // Answer from the counter
   input wire logic [7:0] read_data_in,
   // Byte port
   output logic access_active_out,
   output logic pointer_load_out,
   output logic write_en_out,
   output logic read_en_out,
   output logic [7:0] write_data_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      access_active_out = 1'b0;
      pointer_load_out = 1'b0;
      write_en_out = 1'b0;
      read_en_out = 1'b0;
      write_data_out = 8'h00;
   end

   //////////////////////////////////////////////////////////////////////////
   // One-cycle strobe: 0 pointer, 1 write, 2 read
   task automatic strobe(input logic [1:0] kind, input logic [7:0] data);
      @(negedge clk_in);
      write_data_out = data;
      pointer_load_out = (kind == 2'h0);
      write_en_out = (kind == 2'h1);
      read_en_out = (kind == 2'h2);
      @(negedge clk_in);
      pointer_load_out = 1'b0;
      write_en_out = 1'b0;
      read_en_out = 1'b0;
      // Released data line shows the inverse so a stale byte cannot pass
      write_data_out = ~data;
   endtask : strobe

   task automatic start_access;
      @(negedge clk_in);
      access_active_out = 1'b1;
   endtask : start_access

   task automatic stop_access;
      @(negedge clk_in);
      access_active_out = 1'b0;
   endtask : stop_access

   task automatic set_ptr(input logic [7:0] p);
      strobe(2'h0, p);
   endtask : set_ptr

   task automatic wr(input logic [7:0] d);
      strobe(2'h1, d);
   endtask : wr

   task automatic rd(output logic [7:0] d);
      strobe(2'h2, 8'h00);
      d = read_data_in;
   endtask : rd

   //////////////////////////////////////////////////////////////////////////
   // Whole time block in one short access, seconds first
   task automatic write_time(input logic [55:0] t);
      start_access();
      set_ptr(8'h02);
      for (int i = 6; i >= 0; i--) begin
         wr(t[i*8 +: 8]);
      end
      stop_access();
   endtask : write_time

   task automatic read_time(output logic [55:0] t);
      logic [7:0] d;
      start_access();
      set_ptr(8'h02);
      for (int i = 6; i >= 0; i--) begin
         rd(d);
         t[i*8 +: 8] = d;
      end
      stop_access();
   endtask : read_time
endmodule : host_model

// ### testbench/tb_top.sv
// Self-checking bench for the BCD time and calendar counter
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("FAIL at %0t got %h expected %h", $time, (got), (exp)); \
      end \
   end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_in;
   logic resetn_in;
   logic ce_in;
   logic tick_1hz_in;
   logic supply_low_in;
   logic osc_stopped_in;
   logic access_active_in;
   logic pointer_load_in;
   logic write_en_in;
   logic read_en_in;
   logic [7:0] write_data_in;
   logic [7:0] read_data_out;
   logic integrity_flag_out;
   logic tick_pending_out;
   int bad_count = 0;
   int tests_run = 0;

   bcd_time_calendar_counter i_bcd_time_calendar_counter (
      .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
      .tick_1hz_in(tick_1hz_in), .supply_low_in(supply_low_in), .osc_stopped_in(osc_stopped_in),
      .access_active_in(access_active_in), .pointer_load_in(pointer_load_in),
      .write_en_in(write_en_in), .read_en_in(read_en_in), .write_data_in(write_data_in),
      .read_data_out(read_data_out), .integrity_flag_out(integrity_flag_out),
      .tick_pending_out(tick_pending_out));

   host_model i_host_model (
      .clk_in(clk_in), .read_data_in(read_data_out), .access_active_out(access_active_in),
      .pointer_load_out(pointer_load_in), .write_en_out(write_en_in),
      .read_en_out(read_en_in), .write_data_out(write_data_in));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   // Tick pin pulse long enough to pass the agreement filter
   task automatic tick_pulse;
      @(negedge clk_in);
      tick_1hz_in = 1'b1;
      repeat (8) @(negedge clk_in);
      tick_1hz_in = 1'b0;
      repeat (8) @(negedge clk_in);
   endtask : tick_pulse

   task automatic t_reset;
      logic [55:0] t;
      logic [7:0] d;
      `CHK(integrity_flag_out, 1'b1)
      `CHK(tick_pending_out, 1'b0)
      i_host_model.read_time(t);
      `CHK(t, 56'h80_00_00_01_00_01_00)
      i_host_model.start_access();
      i_host_model.set_ptr(8'h01);
      i_host_model.rd(d);
      `CHK(d, 8'h00)
      i_host_model.rd(d);
      `CHK(d, 8'h80)
      i_host_model.stop_access();
      $display("test reset done");
   endtask : t_reset

   task automatic t_flag;
      logic [55:0] t;
      i_host_model.write_time(56'h00_00_00_01_00_01_00);
      `CHK(integrity_flag_out, 1'b0)
      for (int k = 0; k < 2; k++) begin
         @(negedge clk_in);
         supply_low_in = (k == 0);
         osc_stopped_in = (k == 1);
         repeat (8) @(negedge clk_in);
         `CHK(integrity_flag_out, 1'b1)
         i_host_model.write_time(56'h00_00_00_01_00_01_00);
         `CHK(integrity_flag_out, 1'b1)
         supply_low_in = 1'b0;
         osc_stopped_in = 1'b0;
         repeat (8) @(negedge clk_in);
         `CHK(integrity_flag_out, 1'b1)
         i_host_model.read_time(t);
         `CHK(t[55:48], 8'h80)
         i_host_model.write_time(56'h00_00_00_01_00_01_00);
         `CHK(integrity_flag_out, 1'b0)
      end
      $display("test integrity flag done");
   endtask : t_flag

   // Order: seconds, minutes, hours, day, weekday, century and month, year
   task automatic t_roll;
      logic [55:0] t;
      logic [55:0] start_v [5];
      logic [55:0] exp_v [5];
      start_v = '{56'h59_59_23_31_06_12_99, 56'h59_59_23_28_02_02_00, 56'h59_59_23_29_03_02_04,
                  56'h59_59_23_28_02_02_01, 56'h59_59_23_30_01_09_19};
      exp_v = '{56'h00_00_00_01_00_81_00, 56'h00_00_00_29_03_02_00, 56'h00_00_00_01_04_03_04,
                56'h00_00_00_01_03_03_01, 56'h00_00_00_01_02_10_19};
      for (int i = 0; i < 5; i++) begin
         i_host_model.write_time(start_v[i]);
         tick_pulse();
         i_host_model.read_time(t);
         `CHK(t, exp_v[i])
      end
      $display("test rollover done");
   endtask : t_roll

   task automatic t_freeze;
      logic [55:0] t;
      logic [7:0] d;
      i_host_model.start_access();
      i_host_model.set_ptr(8'h02);
      i_host_model.wr(8'h10);
      tick_pulse();
      tick_pulse();
      `CHK(tick_pending_out, 1'b1)
      i_host_model.set_ptr(8'h02);
      i_host_model.rd(d);
      `CHK(d, 8'h10)
      i_host_model.stop_access();
      repeat (4) @(negedge clk_in);
      `CHK(tick_pending_out, 1'b0)
      i_host_model.read_time(t);
      `CHK(t[55:48], 8'h11)
      $display("test freeze done");
   endtask : t_freeze

   // Clock enable low must hide a tick and a low supply; then a mid-run reset
   task automatic t_hold;
      logic [55:0] t;
      i_host_model.write_time(56'h45_30_12_15_03_06_21);
      @(negedge clk_in);
      ce_in = 1'b0;
      supply_low_in = 1'b1;
      tick_pulse();
      supply_low_in = 1'b0;
      ce_in = 1'b1;
      repeat (8) @(negedge clk_in);
      `CHK(integrity_flag_out, 1'b0)
      tick_pulse();
      i_host_model.read_time(t);
      `CHK(t, 56'h46_30_12_15_03_06_21)
      resetn_in = 1'b0;
      @(negedge clk_in);
      resetn_in = 1'b1;
      `CHK(read_data_out, 8'h00)
      i_host_model.read_time(t);
      `CHK(t, 56'h80_00_00_01_00_01_00)
      $display("test hold done");
   endtask : t_hold

   //////////////////////////////////////////////////////////////////////////
   initial begin
      resetn_in = 1'b0;
      ce_in = 1'b1;
      tick_1hz_in = 1'b0;
      supply_low_in = 1'b0;
      osc_stopped_in = 1'b0;
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      resetn_in = 1'b1;
      t_reset();
      t_flag();
      t_roll();
      t_freeze();
      t_hold();
      close_out();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      bad_count++;
      close_out();
   end
endmodule : tb_top
